// File: verilog/batt_therm_pkg.sv
// Constants shared by the battery thermistor monitor
package batt_therm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OT1_THR_ADDR = 8'h38;
  localparam logic [7:0] UT1_THR_ADDR = 8'h39;
  localparam logic [7:0] OT2_THR_ADDR = 8'h3C;
  localparam logic [7:0] UT2_THR_ADDR = 8'h3D;
  localparam logic [7:0] RESULT_HI_ADDR = 8'h58;
  localparam logic [7:0] RESULT_LO_ADDR = 8'h59;
  localparam logic [7:0] ADC_CHAN_EN_ADDR = 8'h82;
  localparam logic [7:0] SRC_CTRL_ADDR = 8'h84;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADC_TS_EN_BIT = 0;
  localparam int SRC_MODE_LSB = 0;
  localparam int SRC_FSEL_BIT = 2;
  localparam int SRC_LEVEL_LSB = 4;
  localparam int RESULT_LO_BITS = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_LEVEL_RST = 2'h3;
  localparam logic [1:0] SRC_MODE_RST = 2'h2;
  localparam logic SRC_FSEL_RST = 1'b0;
  localparam logic ADC_TS_EN_RST = 1'b0;
  localparam logic [7:0] OT1_THR_RST = 8'h20;
  localparam logic [7:0] UT1_THR_RST = 8'hA0;
  localparam logic [7:0] OT2_THR_RST = 8'h18;
  localparam logic [7:0] UT2_THR_RST = 8'hC0;

  // ----------------------------------------------------------------
  // Switch modes of the sense current
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_MODE_OFF = 2'h0;
  localparam logic [1:0] SRC_MODE_CHARGING = 2'h1;
  localparam logic [1:0] SRC_MODE_ADC_PHASE = 2'h2;
  localparam logic [1:0] SRC_MODE_ALWAYS = 2'h3;

  // ----------------------------------------------------------------
  // Conversion scale and hysteresis, in microvolts at the pin
  // ----------------------------------------------------------------
  localparam int CODE_WIDTH = 12;
  localparam int CODE_STEP_UV = 800;
  localparam int HYST_UT_UV = 460800;
  localparam int HYST_OT_UV = 57600;
  localparam logic [11:0] HYST_UT_CODES = 12'(HYST_UT_UV / CODE_STEP_UV);
  localparam logic [11:0] HYST_OT_CODES = 12'(HYST_OT_UV / CODE_STEP_UV);

  // ----------------------------------------------------------------
  // Event bits
  // ----------------------------------------------------------------
  localparam int EV_COUNT = 5;
  localparam int EV_L1_OVER = 0;
  localparam int EV_L1_UNDER = 1;
  localparam int EV_L1_RETURN = 2;
  localparam int EV_L2_OVER = 3;
  localparam int EV_L2_UNDER = 4;

endpackage

// File: verilog/threshold_tracker.sv
// One temperature threshold with hysteresis and entry/exit pulses
`timescale 1ns/1ps
`default_nettype none

module threshold_tracker #(
  parameter int CODE_W = 12,
  parameter bit HIGH_SIDE = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_clear,
  input wire logic i_sample,
  input wire logic [CODE_W-1:0] i_code,
  input wire logic [CODE_W-1:0] i_level,
  input wire logic [CODE_W-1:0] i_hyst,
  output logic o_active,
  output logic o_enter,
  output logic o_leave
);

  // Checked while the design is elaborated, before anything runs
  if (CODE_W < 2) begin
    $error("threshold_tracker: CODE_W too small");
  end

  logic active_q;
  logic enter_q;
  logic leave_q;
  wire logic [CODE_W:0] code_x = {1'b0, i_code};
  wire logic [CODE_W:0] level_x = {1'b0, i_level};
  wire logic [CODE_W:0] hyst_x = {1'b0, i_hyst};
  // Extra bit keeps the release point from wrapping near the top of the code range
  wire logic beyond = HIGH_SIDE ? (code_x > level_x) : (code_x < level_x);
  wire logic released = HIGH_SIDE ? (code_x + hyst_x <= level_x) : (code_x >= level_x + hyst_x);
  wire logic go_in = i_sample && !active_q && beyond;
  wire logic go_out = i_sample && active_q && released;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      active_q <= 1'b0;
      enter_q <= 1'b0;
      leave_q <= 1'b0;
    end else if (i_clk_en) begin
      active_q <= !i_clear && (go_in || (active_q && !go_out));
      enter_q <= !i_clear && go_in;
      leave_q <= !i_clear && go_out;
    end
  end

  assign o_active = active_q;
  assign o_enter = enter_q;
  assign o_leave = leave_q;

endmodule

`default_nettype wire

// File: verilog/battery_thermistor_monitor.sv
// Battery thermistor monitor: sense current, result capture, thresholds, events
//
// Overview of operation
// - Sense current level field, reset 80uA
// - Current on only during temperature conversion in the reset mode (ADC phase)
// - Switch mode: off, charging, ADC phase, always
// - ADC enable bit gates thermistor conversion
// - Result split high eight, low four
// - One code step is 0.8 mV
// - Always-on mode invalidates auxiliary pin conversions
// - First-level thresholds at 38H and 39H
// - Second-level thresholds at 3CH and 3DH
// - First-level crossing: interrupt, halt, status low
// - Second-level crossing raises interrupt only
// - Release hysteresis 460.8 mV under, 57.6 mV over
// - Returning to window: interrupt, resume, status high
// - Function select makes pin general-purpose input
// - Interrupts follow enable, mode, charging state
`timescale 1ns/1ps
`default_nettype none

module battery_thermistor_monitor #(
  parameter int CODE_W = 12
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd_en,
  output logic [7:0] o_reg_rdata,
  // Interrupt enable and write-one-to-clear of the status bits
  input wire logic [4:0] i_irq_enable,
  input wire logic [4:0] i_irq_clear,
  output logic [4:0] o_irq_status,
  output logic o_irq,
  output logic [4:0] o_event,
  // ADC sequencer on the same clock
  input wire logic i_adc_ts_phase,
  input wire logic i_adc_done,
  input wire logic [CODE_W-1:0] i_adc_code,
  output logic o_adc_ts_enable,
  output logic o_aux_adc_invalid,
  output logic o_general_purpose_analog_input,
  // Thermistor sense pin current source
  output logic o_sense_current_on,
  output logic [1:0] o_sense_current_level,
  // Charger
  input wire logic i_charging,
  output logic o_charge_halt,
  output logic o_batt_temp_good
);

  // Checked while the design is elaborated, before anything runs
  if (CODE_W != batt_therm_pkg::CODE_WIDTH) begin
    $error("battery_thermistor_monitor: CODE_W must match the result registers");
  end

  // ----------------------------------------------------------------
  // Charging level from the charger, synchronised
  // ----------------------------------------------------------------
  logic charging_meta_q;
  logic charging_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      charging_meta_q <= 1'b0;
      charging_q <= 1'b0;
    end else if (i_clk_en) begin
      charging_meta_q <= i_charging;
      charging_q <= charging_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [1:0] src_level_q;
  logic [1:0] src_mode_q;
  logic src_fsel_q;
  logic adc_ts_en_q;
  logic [7:0] ot1_thr_q;
  logic [7:0] ut1_thr_q;
  logic [7:0] ot2_thr_q;
  logic [7:0] ut2_thr_q;
  logic [CODE_W-1:0] result_q;

  wire logic wr_src = i_reg_wr_en && (i_reg_addr == batt_therm_pkg::SRC_CTRL_ADDR);
  wire logic wr_adc = i_reg_wr_en && (i_reg_addr == batt_therm_pkg::ADC_CHAN_EN_ADDR);
  wire logic wr_ot1 = i_reg_wr_en && (i_reg_addr == batt_therm_pkg::OT1_THR_ADDR);
  wire logic wr_ut1 = i_reg_wr_en && (i_reg_addr == batt_therm_pkg::UT1_THR_ADDR);
  wire logic wr_ot2 = i_reg_wr_en && (i_reg_addr == batt_therm_pkg::OT2_THR_ADDR);
  wire logic wr_ut2 = i_reg_wr_en && (i_reg_addr == batt_therm_pkg::UT2_THR_ADDR);

  // Conversions are captured even in general-purpose mode so the pin stays readable
  wire logic capture = i_adc_done && adc_ts_en_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      src_level_q <= batt_therm_pkg::SRC_LEVEL_RST;
      src_mode_q <= batt_therm_pkg::SRC_MODE_RST;
      src_fsel_q <= batt_therm_pkg::SRC_FSEL_RST;
      adc_ts_en_q <= batt_therm_pkg::ADC_TS_EN_RST;
      ot1_thr_q <= batt_therm_pkg::OT1_THR_RST;
      ut1_thr_q <= batt_therm_pkg::UT1_THR_RST;
      ot2_thr_q <= batt_therm_pkg::OT2_THR_RST;
      ut2_thr_q <= batt_therm_pkg::UT2_THR_RST;
      result_q <= '0;
    end else if (i_clk_en) begin
      if (wr_src) begin
        src_level_q <= i_reg_wdata[batt_therm_pkg::SRC_LEVEL_LSB +: 2];
        src_mode_q <= i_reg_wdata[batt_therm_pkg::SRC_MODE_LSB +: 2];
        src_fsel_q <= i_reg_wdata[batt_therm_pkg::SRC_FSEL_BIT];
      end
      if (wr_adc) begin
        adc_ts_en_q <= i_reg_wdata[batt_therm_pkg::ADC_TS_EN_BIT];
      end
      if (wr_ot1) begin
        ot1_thr_q <= i_reg_wdata;
      end
      if (wr_ut1) begin
        ut1_thr_q <= i_reg_wdata;
      end
      if (wr_ot2) begin
        ot2_thr_q <= i_reg_wdata;
      end
      if (wr_ut2) begin
        ut2_thr_q <= i_reg_wdata;
      end
      if (capture) begin
        result_q <= i_adc_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  localparam int LO_PAD = 8 - batt_therm_pkg::RESULT_LO_BITS;
  wire logic [7:0] result_hi = result_q[CODE_W-1 -: 8];
  wire logic [7:0] result_lo = {{LO_PAD{1'b0}}, result_q[batt_therm_pkg::RESULT_LO_BITS-1:0]};
  wire logic [7:0] src_rd = {2'h0, src_level_q, 1'b0, src_fsel_q, src_mode_q};
  wire logic [7:0] adc_rd = {7'h00, adc_ts_en_q};
  wire logic [7:0] rd_mux =
    (i_reg_addr == batt_therm_pkg::OT1_THR_ADDR) ? ot1_thr_q :
    (i_reg_addr == batt_therm_pkg::UT1_THR_ADDR) ? ut1_thr_q :
    (i_reg_addr == batt_therm_pkg::OT2_THR_ADDR) ? ot2_thr_q :
    (i_reg_addr == batt_therm_pkg::UT2_THR_ADDR) ? ut2_thr_q :
    (i_reg_addr == batt_therm_pkg::RESULT_HI_ADDR) ? result_hi :
    (i_reg_addr == batt_therm_pkg::RESULT_LO_ADDR) ? result_lo :
    (i_reg_addr == batt_therm_pkg::ADC_CHAN_EN_ADDR) ? adc_rd :
    (i_reg_addr == batt_therm_pkg::SRC_CTRL_ADDR) ? src_rd : 8'h00;

  logic [7:0] rdata_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
    end else if (i_clk_en && i_reg_rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Current source gating and protection qualifiers
  // ----------------------------------------------------------------
  wire logic src_on_d =
    (src_mode_q == batt_therm_pkg::SRC_MODE_CHARGING) ? charging_q :
    (src_mode_q == batt_therm_pkg::SRC_MODE_ADC_PHASE) ? i_adc_ts_phase :
    (src_mode_q == batt_therm_pkg::SRC_MODE_ALWAYS);
  wire logic aux_invalid_d = (src_mode_q == batt_therm_pkg::SRC_MODE_ALWAYS);

  // Protection armed only in thermistor function with conversion enabled and a switch mode other than off
  wire logic prot_armed = !src_fsel_q && adc_ts_en_q && (src_mode_q != batt_therm_pkg::SRC_MODE_OFF);
  // Mode 01 only watches while charging; trackers hold their state otherwise
  wire logic prot_live = prot_armed && ((src_mode_q != batt_therm_pkg::SRC_MODE_CHARGING) || charging_q);
  wire logic sample = capture && prot_live;
  wire logic clear_trk = !prot_armed;

  // ----------------------------------------------------------------
  // Threshold trackers
  // ----------------------------------------------------------------
  wire logic [CODE_W-1:0] ot1_lvl = {ot1_thr_q, 4'h0};
  wire logic [CODE_W-1:0] ut1_lvl = {ut1_thr_q, 4'h0};
  wire logic [CODE_W-1:0] ot2_lvl = {ot2_thr_q, 4'h0};
  wire logic [CODE_W-1:0] ut2_lvl = {ut2_thr_q, 4'h0};
  logic ot1_act;
  logic ot1_in;
  logic ut1_act;
  logic ut1_in;
  logic ot2_in;
  logic ut2_in;

  threshold_tracker #(.CODE_W(CODE_W), .HIGH_SIDE(1'b0)) u_ot1 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_clear(clear_trk),
    .i_sample(sample),
    .i_code(i_adc_code),
    .i_level(ot1_lvl),
    .i_hyst(batt_therm_pkg::HYST_OT_CODES),
    .o_active(ot1_act),
    .o_enter(ot1_in),
    .o_leave()
  );

  threshold_tracker #(.CODE_W(CODE_W), .HIGH_SIDE(1'b1)) u_ut1 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_clear(clear_trk),
    .i_sample(sample),
    .i_code(i_adc_code),
    .i_level(ut1_lvl),
    .i_hyst(batt_therm_pkg::HYST_UT_CODES),
    .o_active(ut1_act),
    .o_enter(ut1_in),
    .o_leave()
  );

  threshold_tracker #(.CODE_W(CODE_W), .HIGH_SIDE(1'b0)) u_ot2 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_clear(clear_trk),
    .i_sample(sample),
    .i_code(i_adc_code),
    .i_level(ot2_lvl),
    .i_hyst(batt_therm_pkg::HYST_OT_CODES),
    .o_active(),
    .o_enter(ot2_in),
    .o_leave()
  );

  threshold_tracker #(.CODE_W(CODE_W), .HIGH_SIDE(1'b1)) u_ut2 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_clear(clear_trk),
    .i_sample(sample),
    .i_code(i_adc_code),
    .i_level(ut2_lvl),
    .i_hyst(batt_therm_pkg::HYST_UT_CODES),
    .o_active(),
    .o_enter(ut2_in),
    .o_leave()
  );

  // ----------------------------------------------------------------
  // Temperature-good status, charger halt, events
  // ----------------------------------------------------------------
  logic temp_good_q;
  logic halt_q;
  logic [4:0] event_q;
  logic [4:0] status_q;

  wire logic good_now = !(ot1_act || ut1_act);
  // A return is only reported from inside protection; disarming is silent
  wire logic l1_return = good_now && !temp_good_q && prot_armed;
  wire logic [4:0] event_d = {ut2_in, ot2_in, l1_return, ut1_in, ot1_in};
  wire logic [4:0] status_set = event_d & i_irq_enable;
  // Set wins over a clear in the same cycle so no event is lost
  wire logic [4:0] status_d = status_set | (status_q & ~i_irq_clear);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      temp_good_q <= 1'b1;
      halt_q <= 1'b0;
      event_q <= 5'h00;
      status_q <= 5'h00;
    end else if (i_clk_en) begin
      temp_good_q <= good_now;
      // Own flop so the charger sees a clean registered level
      halt_q <= !good_now;
      event_q <= event_d;
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic src_on_q;
  logic aux_invalid_q;
  logic gp_mode_q;
  logic irq_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      src_on_q <= 1'b0;
      aux_invalid_q <= 1'b0;
      gp_mode_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (i_clk_en) begin
      src_on_q <= src_on_d;
      aux_invalid_q <= aux_invalid_d;
      gp_mode_q <= src_fsel_q;
      irq_q <= |status_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_irq_status = status_q;
  assign o_irq = irq_q;
  assign o_event = event_q;
  assign o_adc_ts_enable = adc_ts_en_q;
  assign o_aux_adc_invalid = aux_invalid_q;
  assign o_general_purpose_analog_input = gp_mode_q;
  assign o_sense_current_on = src_on_q;
  assign o_sense_current_level = src_level_q;
  assign o_charge_halt = halt_q;
  assign o_batt_temp_good = temp_good_q;

endmodule

`default_nettype wire

// File: bench/batt_therm_sva.sv
// Assertion checker bound to the battery thermistor monitor
`timescale 1ns/1ps
`default_nettype none
module batt_therm_sva (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [4:0] i_irq_enable,
  input wire logic [4:0] o_irq_status,
  input wire logic [4:0] o_event,
  input wire logic i_adc_ts_phase,
  input wire logic o_adc_ts_enable,
  input wire logic o_aux_adc_invalid,
  input wire logic o_sense_current_on,
  input wire logic [1:0] o_sense_current_level,
  input wire logic o_charge_halt,
  input wire logic o_batt_temp_good
);
  // ------
  // Shadow of the switch mode, so the current can be judged from ports alone
  // ------
  logic [1:0] mode_q;
  wire logic wr_src = i_clk_en && i_reg_wr_en && i_reg_addr == 8'h84;
  wire logic wr_adc = i_clk_en && i_reg_wr_en && i_reg_addr == 8'h82;
  wire logic [1:0] wd_lvl = i_reg_wdata[5:4];
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      mode_q <= 2'h2;
    end else if (wr_src) begin
      mode_q <= i_reg_wdata[1:0];
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_level;
    wr_src |-> ##2 o_sense_current_level == $past(wd_lvl, 2);
  endproperty
  a_level: assert property (p_level) else $error("current level not taken");
  property p_src_adc;
    mode_q == 2'h2 && !wr_src |=> o_sense_current_on == $past(i_adc_ts_phase);
  endproperty
  a_src_adc: assert property (p_src_adc) else $error("current not following conversion");
  property p_src_off;
    mode_q == 2'h0 && !wr_src |=> !o_sense_current_on;
  endproperty
  a_src_off: assert property (p_src_off) else $error("current on in off mode");
  property p_adc_en;
    wr_adc && i_reg_wdata[0] |-> ##2 o_adc_ts_enable;
  endproperty
  a_adc_en: assert property (p_adc_en) else $error("conversion enable not set");
  property p_aux;
    wr_src && i_reg_wdata[1:0] == 2'h3 |-> ##2 o_aux_adc_invalid;
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary pin not marked invalid");
  property p_over;
    o_event[0] |-> !o_batt_temp_good && o_charge_halt;
  endproperty
  a_over: assert property (p_over) else $error("no halt on first level crossing");
  property p_return;
    o_event[2] |-> o_batt_temp_good && !o_charge_halt ##1 !o_event[2];
  endproperty
  a_return: assert property (p_return) else $error("no resume on return");
  property p_status;
    o_event != 5'h00 |-> (o_event & $past(i_irq_enable) & ~o_irq_status) == 5'h00;
  endproperty
  a_status: assert property (p_status) else $error("enabled event not recorded");
  property p_pulse;
    o_event[3] |=> !o_event[3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
  c_over: cover property (o_event[0]);
  c_return: cover property (o_event[2]);
  c_level2: cover property (o_event[3]);
endmodule
bind battery_thermistor_monitor batt_therm_sva u_sva (
  .i_core_clk, .i_nrst, .i_clk_en, .i_reg_addr, .i_reg_wr_en, .i_reg_wdata, .i_irq_enable,
  .o_irq_status, .o_event, .i_adc_ts_phase, .o_adc_ts_enable, .o_aux_adc_invalid,
  .o_sense_current_on, .o_sense_current_level, .o_charge_halt, .o_batt_temp_good);
`default_nettype wire

// File: bench/therm_charger_model.sv
// Thermistor on the sense pin and the charger it can halt
`timescale 1ns/1ps
`default_nettype none
module therm_charger_model (
  input wire logic i_sense_current_on,
  input wire logic [1:0] i_sense_current_level,
  input wire logic i_charge_halt,
  input wire logic i_want_charge,
  input wire logic [31:0] i_r_ohm,
  output logic [11:0] o_code,
  output logic o_charging
);
  logic [31:0] ua;
  logic [31:0] full;
  // Level 0..3 gives 20..80uA; no current means no voltage, so the code drops
  assign ua = 32'h14 * ({30'h0, i_sense_current_level} + 32'h1);
  assign full = i_sense_current_on ? i_r_ohm * ua / 32'h320 : 32'h0;
  assign o_code = full > 32'hFFF ? 12'hFFF : full[11:0];
  assign o_charging = i_want_charge && !i_charge_halt;
endmodule
`default_nettype wire

// File: bench/battery_thermistor_monitor_bench.sv
// Self-checking bench for the battery thermistor monitor
`timescale 1ns/1ps
`default_nettype none
module battery_thermistor_monitor_bench;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, done = 1'b0, ts_phase = 1'b0, want = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0] irq_en = 5'h1F, irq_clr = 5'h00, status, ev, evacc;
  logic [31:0] r_ohm = 32'h0;
  logic [11:0] code;
  logic [1:0] cur_lvl;
  logic irq, ts_en, aux_inv, gp_in, cur_on, charging, halt, good;
  int n_fail = 0;
  int checked = 0;
  // ------
  // Tables: at 80uA the code is the resistance in ohms over ten
  // ------
  localparam logic [7:0] regs [8] = '{8'h84, 8'h82, 8'h38, 8'h39, 8'h3C, 8'h3D, 8'h58, 8'h59};
  localparam logic [7:0] rstv [8] = '{8'h32, 8'h00, 8'h20, 8'hA0, 8'h18, 8'hC0, 8'h00, 8'h00};
  localparam logic [31:0] rtab [8] = '{32'h1388, 32'h157C, 32'h1770, 32'hBB8, 32'h2710, 32'h6590,
    32'h4E20, 32'h4A38};
  localparam logic [4:0] etab [8] = '{5'h01, 5'h00, 5'h04, 5'h09, 5'h04, 5'h02, 5'h00, 5'h04};
  localparam logic [7:0] gtab = 8'h94;
  battery_thermistor_monitor #(.CODE_W(12)) DUT (
    .i_core_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1), .i_reg_addr(addr), .i_reg_wr_en(wr),
    .i_reg_wdata(wdata), .i_reg_rd_en(rd), .o_reg_rdata(rdata), .i_irq_enable(irq_en),
    .i_irq_clear(irq_clr), .o_irq_status(status), .o_irq(irq), .o_event(ev), .i_adc_ts_phase(ts_phase),
    .i_adc_done(done), .i_adc_code(code), .o_adc_ts_enable(ts_en), .o_aux_adc_invalid(aux_inv),
    .o_general_purpose_analog_input(gp_in), .o_sense_current_on(cur_on),
    .o_sense_current_level(cur_lvl), .i_charging(charging), .o_charge_halt(halt), .o_batt_temp_good(good));
  therm_charger_model model (.i_sense_current_on(cur_on), .i_sense_current_level(cur_lvl),
    .i_charge_halt(halt), .i_want_charge(want), .i_r_ohm(r_ohm), .o_code(code), .o_charging(charging));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk8(rdata, exp);
  endtask
  // One conversion; events stand one cycle each, so three cycles are gathered
  task automatic conv(input logic [31:0] r, input logic [4:0] exp);
    @(negedge clk);
    r_ohm = r;
    ts_phase = 1'b1;
    repeat (2) @(negedge clk);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    ts_phase = 1'b0;
    evacc = 5'h00;
    repeat (3) begin
      @(negedge clk);
      evacc = evacc | ev;
    end
    chk8({3'h0, evacc}, {3'h0, exp});
  endtask
  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_chk(regs[i], rstv[i]);
    end
    chk1(good, 1'b1);
    for (int i = 2; i < 6; i++) begin
      wr_reg(regs[i], ~rstv[i]);
      rd_chk(regs[i], ~rstv[i]);
      wr_reg(regs[i], rstv[i]);
    end
    rd_chk(8'h00, 8'h00);
    wr_reg(8'h58, 8'hFF);
    rd_chk(8'h58, 8'h00);
    wr_reg(8'h84, 8'hFF);
    rd_chk(8'h84, 8'h37);
    done_test("registers");
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h84, 8'h30 | 8'(m));
      for (int p = 0; p < 2; p++) begin
        ts_phase = p[0];
        want = p[0];
        repeat (5) @(negedge clk);
        chk1(cur_on, m == 3 || (m != 0 && p == 1));
      end
      chk1(aux_inv, m == 3);
    end
    for (int l = 0; l < 4; l++) begin
      wr_reg(8'h84, {2'h0, 2'(l), 4'h3});
      repeat (2) @(negedge clk);
      chk8({6'h0, cur_lvl}, 8'(l));
    end
    done_test("modes");
    wr_reg(8'h84, 8'h32);
    conv(32'h2710, 5'h00);
    rd_chk(8'h58, 8'h00);
    wr_reg(8'h82, 8'h01);
    chk1(ts_en, 1'b1);
    conv(32'h2710, 5'h00);
    rd_chk(8'h58, 8'h3E);
    rd_chk(8'h59, 8'h08);
    want = 1'b1;
    for (int i = 0; i < 8; i++) begin
      irq_en = (i == 3) ? 5'h00 : 5'h1F;
      conv(rtab[i], etab[i]);
      chk8({3'h0, status}, {3'h0, etab[i] & irq_en});
      chk1(irq, (etab[i] & irq_en) != 5'h00);
      chk1(good, gtab[i]);
      chk1(halt, !gtab[i]);
      chk1(charging, gtab[i]);
      irq_clr = 5'h1F;
      @(negedge clk);
      irq_clr = 5'h00;
      chk1(irq, 1'b0);
    end
    conv(32'h7D00, 5'h12);
    chk1(good, 1'b0);
    conv(32'h4A38, 5'h04);
    chk8({3'h0, status}, 8'h16);
    done_test("thresholds");
    wr_reg(8'h84, 8'h31);
    conv(32'hBB8, 5'h09);
    conv(32'h2710, 5'h00);
    chk1(good, 1'b0);
    wr_reg(8'h84, 8'h30);
    // Trackers clear one edge after the write, the good flag one edge later
    repeat (2) @(negedge clk);
    chk1(good, 1'b1);
    conv(32'hBB8, 5'h00);
    wr_reg(8'h84, 8'h36);
    conv(32'hBB8, 5'h00);
    chk1(gp_in, 1'b1);
    wr_reg(8'h82, 8'h00);
    wr_reg(8'h84, 8'h33);
    conv(32'hBB8, 5'h00);
    done_test("gating");
    stop_test;
  end
endmodule
`default_nettype wire
